// >>> shared/salm_pkg.sv
package salm_pkg;

  // ***************************************************
  // Widths and counts
  // ***************************************************
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned REST_W        = 6;
  localparam int unsigned LINE_CHANNELS = 2;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam logic [2:0]  BIT_CNT_LAST  = 3'h7;
  localparam logic [2:0]  BIT_CNT_FIRST = 3'h0;

  // ***************************************************
  // Register map (direct addresses)
  // ***************************************************
  localparam logic [15:0] IO_CTRL_CH6_ADDR  = 16'h7f01;
  localparam logic [15:0] IO_CTRL_CH10_ADDR = 16'hbf01;
  localparam logic [7:0]  IO_CTRL_RESET     = 8'h00;
  localparam logic [7:0]  RDATA_UNMAPPED    = 8'h00;
  localparam int unsigned EDGE_INVERT_BIT   = 1;

  // ***************************************************
  // Bus bit positions of the shared pins and line channel indices
  // ***************************************************
  localparam int unsigned SHARED_BIT_CH6  = 3;
  localparam int unsigned SHARED_BIT_CH10 = 4;
  localparam int unsigned CH6_IDX         = 0;
  localparam int unsigned CH10_IDX        = 1;

endpackage : salm_pkg

// >>> rtl/salm_top.sv
// Overview of operation
// R1: Bus enabled: pins are add-bus bits; disabled: pins are line data inputs.
// R2: Bus mode samples pins on add clock falling edge as one byte.
// R3: Transceiver drives single-rail recovered serial data from its positive rail.
// R4: Bus bit 3 pin feeds channel 6, bit 4 pin feeds channel 10.
// R5: Line data latched on falling edge of its channel clock by default.
// R6: Bit 1 of I/O control at 0x7F01/0xBF01 selects rising edge.
// R7: STS-1 mode always samples on the falling edge.
// R8: Transceiver supplies recovered clock; device captures line data with it.

// ***************************************************
// Synchronous FIFO, valid/ready on both sides
// ***************************************************
module salm_fifo #(
  parameter int unsigned WIDTH = salm_pkg::DATA_W,
  parameter int unsigned DEPTH = salm_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out  = (count != (PW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = mem[rd_ptr];

  // Storage array, written only on push
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      count <= (PW+1)'(count + {PW'(0), push} - {PW'(0), pop});
    end
  end
endmodule : salm_fifo

// ***************************************************
// Shared add-bus / line data input pins
// ***************************************************
module salm_top (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        add_bus_clock_ch2_in,
  input  wire logic        line_clock_in_ch6_in,
  input  wire logic        line_clock_in_ch10_in,
  input  wire logic        shared_pin3_in,
  input  wire logic        shared_pin4_in,
  input  wire logic [5:0]  add_bus_rest_in,
  input  wire logic        bus_enable_ch2_in,
  input  wire logic        sts1_mode_ch6_in,
  input  wire logic        sts1_mode_ch10_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic [7:0]  cpu_wdata_in,
  input  wire logic        cpu_wr_in,
  input  wire logic        cpu_rd_in,
  output logic      [7:0]  cpu_rdata_out,
  output logic      [7:0]  add_bus_data_ch2_out,
  output logic             add_bus_valid_out,
  input  wire logic        add_bus_ready_in,
  output logic             add_fifo_ready_out,
  output logic             add_overrun_out,
  output logic      [7:0]  line_byte_ch6_out,
  output logic             line_byte_ch6_valid_out,
  output logic      [7:0]  line_byte_ch10_out,
  output logic             line_byte_ch10_valid_out,
  output logic             line_mode_out
);
  localparam int unsigned NCH = salm_pkg::LINE_CHANNELS;
  // Rebuild the byte: rest holds bits 7:5 and 2:0
  function automatic logic [7:0] merge_word(input logic [5:0] rest,
                                            input logic       b3,
                                            input logic       b4);
    merge_word = {rest[5:3], b4, b3, rest[2:0]};
  endfunction : merge_word

  // ***************************************************
  // System domain: control synchronisers
  // ***************************************************
  logic [1:0]     bus_en_sys_sync;
  logic [1:0]     sts1_sys_sync [NCH];
  logic           bus_en_sys;
  logic [NCH-1:0] sts1_sys;
  logic [7:0]     io_ctrl [NCH];
  logic [NCH-1:0] edge_rise_sel;
  // Pins are asynchronous: two flops before use
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_en_sys_sync  <= 2'h0;
      sts1_sys_sync[0] <= 2'h0;
      sts1_sys_sync[1] <= 2'h0;
    end else begin
      bus_en_sys_sync  <= {bus_en_sys_sync[0], bus_enable_ch2_in};
      sts1_sys_sync[0] <= {sts1_sys_sync[0][0], sts1_mode_ch6_in};
      sts1_sys_sync[1] <= {sts1_sys_sync[1][0], sts1_mode_ch10_in};
    end
  end

  assign bus_en_sys    = bus_en_sys_sync[1];
  assign sts1_sys      = {sts1_sys_sync[1][1], sts1_sys_sync[0][1]};
  assign line_mode_out = ~bus_en_sys;                              // [R1]

  // ***************************************************
  // Register port (direct address)
  // ***************************************************
  // I/O control writes; both registers fully read/write
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      io_ctrl[0] <= salm_pkg::IO_CTRL_RESET;
      io_ctrl[1] <= salm_pkg::IO_CTRL_RESET;
    end else if (cpu_wr_in) begin
      if (cpu_addr_in == salm_pkg::IO_CTRL_CH6_ADDR) begin
        io_ctrl[salm_pkg::CH6_IDX] <= cpu_wdata_in;                // [R6]
      end
      if (cpu_addr_in == salm_pkg::IO_CTRL_CH10_ADDR) begin
        io_ctrl[salm_pkg::CH10_IDX] <= cpu_wdata_in;               // [R6]
      end
    end
  end

  // Read data held until the next read; unmapped reads give zero
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cpu_rdata_out <= salm_pkg::RDATA_UNMAPPED;
    end else if (cpu_rd_in) begin
      if (cpu_addr_in == salm_pkg::IO_CTRL_CH6_ADDR) begin
        cpu_rdata_out <= io_ctrl[salm_pkg::CH6_IDX];
      end else if (cpu_addr_in == salm_pkg::IO_CTRL_CH10_ADDR) begin
        cpu_rdata_out <= io_ctrl[salm_pkg::CH10_IDX];
      end else begin
        cpu_rdata_out <= salm_pkg::RDATA_UNMAPPED;
      end
    end
  end

  // Rising edge only when asked and not in STS-1; registered so the
  // link domain sees one glitch-free level
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      edge_rise_sel <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        edge_rise_sel[i] <= io_ctrl[i][salm_pkg::EDGE_INVERT_BIT]  // [R6]
                            & ~sts1_sys[i];                        // [R7]
      end
    end
  end

  // ***************************************************
  // Add bus clock domain (falling edge)
  // ***************************************************
  logic [1:0] bus_en_bclk_sync;
  logic [7:0] bus_word_hold;
  logic       bus_word_tog;
  // Enable crossed into the bus clock domain
  always_ff @(negedge add_bus_clock_ch2_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_en_bclk_sync <= 2'h0;
    end else begin
      bus_en_bclk_sync <= {bus_en_bclk_sync[0], bus_enable_ch2_in};
    end
  end

  // One byte per falling edge while the bus is enabled
  always_ff @(negedge add_bus_clock_ch2_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_word_hold <= 8'h00;
      bus_word_tog  <= 1'b0;
    end else if (bus_en_bclk_sync[1]) begin                        // [R1]
      bus_word_hold <= merge_word(add_bus_rest_in,
                                  shared_pin3_in, shared_pin4_in); // [R2]
      bus_word_tog  <= ~bus_word_tog;
    end
  end

  // ***************************************************
  // Bus words into the system domain and FIFO
  // ***************************************************
  logic [2:0] bus_tog_sync;
  logic [7:0] bus_push_data;
  logic       bus_push_valid;
  // Toggle crossing; the held word is stable for a whole bus period,
  // which outlasts the three system cycles the crossing takes
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_tog_sync <= 3'h0;
    end else begin
      bus_tog_sync <= {bus_tog_sync[1:0], bus_word_tog};
    end
  end

  // Word register feeding the FIFO
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_push_data  <= 8'h00;
      bus_push_valid <= 1'b0;
    end else begin
      bus_push_valid <= bus_tog_sync[2] ^ bus_tog_sync[1];
      if (bus_tog_sync[2] ^ bus_tog_sync[1]) begin
        bus_push_data <= bus_word_hold;
      end
    end
  end

  // The pin stream cannot stall: a word offered to a full FIFO is lost
  // and flagged; the flag clears when the bus is disabled
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      add_overrun_out <= 1'b0;
    end else if (bus_push_valid & ~add_fifo_ready_out) begin
      add_overrun_out <= 1'b1;
    end else if (!bus_en_sys) begin
      add_overrun_out <= 1'b0;
    end
  end

  salm_fifo #(
    .WIDTH (salm_pkg::DATA_W),
    .DEPTH (salm_pkg::FIFO_DEPTH)
  ) u_add_fifo (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .in_data_in    (bus_push_data),
    .in_valid_in   (bus_push_valid),
    .in_ready_out  (add_fifo_ready_out),
    .out_data_out  (add_bus_data_ch2_out),
    .out_valid_out (add_bus_valid_out),
    .out_ready_in  (add_bus_ready_in)
  );

  // ***************************************************
  // Line channels 6 and 10
  // ***************************************************
  logic [NCH-1:0] lclk;
  logic [NCH-1:0] ldata;
  logic [7:0]     line_byte [NCH];
  logic [NCH-1:0] line_valid;
  // Pin 3 serves channel 6, pin 4 serves channel 10
  assign lclk  = {line_clock_in_ch10_in, line_clock_in_ch6_in};   // [R8]
  assign ldata = {shared_pin4_in, shared_pin3_in};                // [R4]

  for (genvar g = 0; g < NCH; g++) begin : g_line
    logic [1:0] en_sync;
    logic [1:0] rise_sync;
    logic       fall_bit;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [7:0] byte_hold;
    logic       byte_tog;
    logic [2:0] tog_sync;
    // Mode and edge select crossed into the line clock domain
    always_ff @(posedge lclk[g] or negedge resetn_in) begin
      if (!resetn_in) begin
        en_sync   <= 2'h0;
        rise_sync <= 2'h0;
      end else begin
        en_sync   <= {en_sync[0], ~bus_enable_ch2_in};
        rise_sync <= {rise_sync[0], edge_rise_sel[g]};
      end
    end

    // Default capture on the falling edge of the recovered clock
    always_ff @(negedge lclk[g] or negedge resetn_in) begin
      if (!resetn_in) begin
        fall_bit <= 1'b0;
      end else begin
        fall_bit <= ldata[g];                                      // [R5] [R8]
      end
    end

    // Shift in the rising-edge sample or the held falling-edge one
    always_ff @(posedge lclk[g] or negedge resetn_in) begin
      if (!resetn_in) begin
        shift     <= 8'h00;
        bit_cnt   <= salm_pkg::BIT_CNT_FIRST;
        byte_hold <= 8'h00;
        byte_tog  <= 1'b0;
      end else if (en_sync[1]) begin                               // [R1]
        shift   <= {shift[6:0], rise_sync[1] ? ldata[g] : fall_bit}; // [R5] [R6] [R7]
        bit_cnt <= 3'(bit_cnt + 1'b1);
        if (bit_cnt == salm_pkg::BIT_CNT_LAST) begin
          byte_hold <= {shift[6:0], rise_sync[1] ? ldata[g] : fall_bit};
          byte_tog  <= ~byte_tog;
        end
      end else begin
        bit_cnt <= salm_pkg::BIT_CNT_FIRST;
      end
    end

    // Byte handed over by toggle; a byte spans eight line clocks
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
        tog_sync      <= 3'h0;
        line_byte[g]  <= 8'h00;
        line_valid[g] <= 1'b0;
      end else begin
        tog_sync      <= {tog_sync[1:0], byte_tog};
        line_valid[g] <= tog_sync[2] ^ tog_sync[1];
        if (tog_sync[2] ^ tog_sync[1]) begin
          line_byte[g] <= byte_hold;
        end
      end
    end
  end
  assign line_byte_ch6_out        = line_byte[salm_pkg::CH6_IDX];
  assign line_byte_ch6_valid_out  = line_valid[salm_pkg::CH6_IDX];
  assign line_byte_ch10_out       = line_byte[salm_pkg::CH10_IDX];
  assign line_byte_ch10_valid_out = line_valid[salm_pkg::CH10_IDX];
endmodule : salm_top

// >>> dv/salm_properties.sv
// ***************************************************
// Port checker for the shared pin block
// ***************************************************
module salm_chk (
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire logic        bus_enable_ch2_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic        cpu_rd_in,
  input wire logic [7:0]  cpu_rdata_out,
  input wire logic [7:0]  add_bus_data_ch2_out,
  input wire logic        add_bus_valid_out,
  input wire logic        add_bus_ready_in,
  input wire logic        add_fifo_ready_out,
  input wire logic        add_overrun_out,
  input wire logic        line_byte_ch6_valid_out,
  input wire logic        line_byte_ch10_valid_out,
  input wire logic        line_mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  // Bus mode dwell, saturating so that bytes still in flight have drained
  logic [5:0] bus_cnt;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_cnt <= 6'h00;
    end else begin
      bus_cnt <= !bus_enable_ch2_in ? 6'h00 : bus_cnt + {5'h00, bus_cnt != 6'h3f};
    end
  end

  // Steady enable, then a stalled head
  sequence s_bus_steady;
    bus_enable_ch2_in [*4];
  endsequence
  sequence s_head_held;
    add_bus_valid_out && !add_bus_ready_in;
  endsequence

  a_bus_hides_line: assert property (s_bus_steady |-> !line_mode_out)
    else $error("line mode shown while bus enabled");
  a_bus_no_bytes: assert property (bus_cnt == 6'h3f |->
    !(line_byte_ch6_valid_out || line_byte_ch10_valid_out))
    else $error("line byte produced in bus mode");
  a_head_held: assert property (s_head_held |=>
    add_bus_valid_out && $stable(add_bus_data_ch2_out))
    else $error("fifo head changed without pop");
  a_full_has_data: assert property (!add_fifo_ready_out |-> add_bus_valid_out)
    else $error("fifo full but nothing offered");
  a_overrun_cause: assert property ($rose(add_overrun_out) |->
    $past(add_fifo_ready_out) == 1'b0)
    else $error("overrun raised with room in fifo");
  a_overrun_sticky: assert property (s_bus_steady ##0 add_overrun_out |=> add_overrun_out)
    else $error("overrun dropped in bus mode");
  a_byte_pulse_ch6: assert property (line_byte_ch6_valid_out |=> !line_byte_ch6_valid_out)
    else $error("ch6 byte valid longer than a cycle");
  a_rdata_held: assert property (!cpu_rd_in |=> $stable(cpu_rdata_out))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (cpu_rd_in && cpu_addr_in != salm_pkg::IO_CTRL_CH6_ADDR
    && cpu_addr_in != salm_pkg::IO_CTRL_CH10_ADDR |=> cpu_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule : salm_chk

// >>> dv/salm_line_model.sv
// ***************************************************
// Line transceiver: recovered clock and data
// ***************************************************
module salm_line_model (
  input  wire logic       start_in,
  input  wire logic [7:0] byte_in,
  input  wire logic [3:0] len_in,
  input  wire logic       rise_in,
  output logic            clk_out,
  output logic            data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock stands high between frames
  initial begin
    clk_out = 1'b1;
    data_out = 1'b0;
  end

  // MSB first, data valid only around the intended edge
  always @(posedge start_in) begin
    for (int i = 7; i > 7 - int'(len_in); i--) begin
      data_out = rise_in ? ~byte_in[i] : byte_in[i];
      #20 clk_out = 1'b0;
      #20 data_out = ~data_out;
      #20 clk_out = 1'b1;
      #20;
    end
    data_out = ~data_out;
  end
endmodule : salm_line_model

// >>> dv/test_shared_add_bus_line_input_mux.sv
module test_shared_add_bus_line_input_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        bus_clk = 1'b0;
  logic        bus_en = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        ready = 1'b0;
  logic [7:0]  bus_w = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [15:0] addr = 16'h0000;
  logic [3:0]  len = 4'h8;
  logic [1:0]  sts = 2'h0;
  logic [1:0]  go = 2'h0;
  logic [1:0]  rise = 2'h0;
  logic [7:0]  lb [2];
  wire  [1:0]  lck;
  wire  [1:0]  ld;
  wire  [7:0]  rdata, bdata, b6, b10;
  wire         bvalid, fready, ovr, v6, v10, lmode;
  logic [7:0]  qb[$], q6[$], q10[$], qr[$];
  int          bad_count = 0;
  int          cmp_count = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  salm_top dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .add_bus_clock_ch2_in(bus_clk),
    .line_clock_in_ch6_in(lck[0]), .line_clock_in_ch10_in(lck[1]),
    .shared_pin3_in(bus_en ? bus_w[3] : ld[0]), .shared_pin4_in(bus_en ? bus_w[4] : ld[1]),
    .add_bus_rest_in({bus_w[7:5], bus_w[2:0]}), .bus_enable_ch2_in(bus_en),
    .sts1_mode_ch6_in(sts[0]), .sts1_mode_ch10_in(sts[1]), .cpu_addr_in(addr),
    .cpu_wdata_in(wdata), .cpu_wr_in(wr), .cpu_rd_in(rd), .cpu_rdata_out(rdata),
    .add_bus_data_ch2_out(bdata), .add_bus_valid_out(bvalid), .add_bus_ready_in(ready),
    .add_fifo_ready_out(fready), .add_overrun_out(ovr), .line_byte_ch6_out(b6),
    .line_byte_ch6_valid_out(v6), .line_byte_ch10_out(b10), .line_byte_ch10_valid_out(v10),
    .line_mode_out(lmode));

  // ***************************************************
  // Line partners for channels 6 and 10
  // ***************************************************
  for (genvar c = 0; c < 2; c++) begin : g_line
    salm_line_model u_line (.start_in(go[c]), .byte_in(lb[c]), .len_in(len),
      .rise_in(rise[c]), .clk_out(lck[c]), .data_out(ld[c]));
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Register access, one cycle each; reads note their expected value
  task automatic acc(input bit w, input logic [15:0] a, input logic [7:0] d);
    if (!w) qr.push_back(d);
    @(negedge clk_sys_in);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk_sys_in);
    wr = 1'b0;
    rd = 1'b0;
  endtask : acc

  // Bus words set 23 ns before the rising edge, taken on the falling one
  task automatic bus_send(input int n, input int keep);
    for (int i = 0; i < n; i++) begin
      bus_w = 8'($urandom);
      if (i < keep) qb.push_back(bus_w);
      #23 bus_clk = 1'b1;
      #40 bus_clk = 1'b0;
      #17;
    end
    bus_w = ~bus_w;
    #3;
  endtask : bus_send

  // Both channels at once; only whole bytes are expected
  task automatic line_send(input logic [3:0] n);
    len = n;
    lb[0] = 8'($urandom);
    lb[1] = 8'($urandom);
    if (n == 4'h8) q6.push_back(lb[0]);
    if (n == 4'h8) q10.push_back(lb[1]);
    #3 go = 2'h3;
    #1 go = 2'h0;
    #(80 * n + 20);
  endtask : line_send

  // Output watcher: oldest note against each result
  always @(posedge clk_sys_in) begin
    if (bvalid && ready) begin
      chk("bus word", bdata, qb.size() > 0 ? qb.pop_front() : 8'hxx);
    end
    if (v6) chk("ch6 byte", b6, q6.size() > 0 ? q6.pop_front() : 8'hxx);
    if (v10) chk("ch10 byte", b10, q10.size() > 0 ? q10.pop_front() : 8'hxx);
    if (rd_d) chk("reg read", rdata, qr.pop_front());
    rd_d = rd;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // Watchdog far beyond the expected ten microseconds
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h4336));
    repeat (12) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    resetn_in = 1'b1;
    acc(0, salm_pkg::IO_CTRL_CH6_ADDR, salm_pkg::IO_CTRL_RESET);
    acc(0, salm_pkg::IO_CTRL_CH10_ADDR, salm_pkg::IO_CTRL_RESET);
    acc(1, salm_pkg::IO_CTRL_CH6_ADDR, 8'ha5);
    acc(1, 16'h7f02, 8'hff);
    acc(0, 16'h7f02, salm_pkg::RDATA_UNMAPPED);
    acc(0, salm_pkg::IO_CTRL_CH6_ADDR, 8'ha5);
    $display("register test done");
    // Settling words flushed, then 20 words into a stalled 16 deep fifo
    bus_send(2, 0);
    @(negedge clk_sys_in);
    ready = 1'b1;
    repeat (20) @(negedge clk_sys_in);
    ready = 1'b0;
    chk("line mode", lmode, 1'b0);
    bus_send(20, 16);
    chk("fifo ready", fready, 1'b0);
    chk("overrun", ovr, 1'b1);
    repeat (4) @(negedge clk_sys_in);
    ready = 1'b1;
    repeat (40) @(negedge clk_sys_in);
    chk("fifo valid", bvalid, 1'b0);
    $display("bus test done");
    // Edge select per channel; sts1 must keep the falling edge
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_sys_in);
      bus_en = 1'b1;
      sts = {k[1], k[1]};
      acc(1, salm_pkg::IO_CTRL_CH6_ADDR, {6'h00, k[0], 1'b0});
      acc(1, salm_pkg::IO_CTRL_CH10_ADDR, {6'h00, !k[0], 1'b0});
      rise = {!k[0], k[0]} & ~sts;
      line_send(4'h3);
      @(negedge clk_sys_in);
      bus_en = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      chk("line mode", lmode, 1'b1);
      chk("overrun", ovr, 1'b0);
      line_send(4'h2);
      line_send(4'h8);
      line_send(4'h8);
      repeat (10) @(negedge clk_sys_in);
    end
    chk("pending", 8'(qb.size() + q6.size() + q10.size()), 8'h00);
    $display("line test done");
    finish_test();
  end
endmodule : test_shared_add_bus_line_input_mux

bind salm_top salm_chk u_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .bus_enable_ch2_in(bus_enable_ch2_in), .cpu_addr_in(cpu_addr_in), .cpu_rd_in(cpu_rd_in),
  .cpu_rdata_out(cpu_rdata_out), .add_bus_data_ch2_out(add_bus_data_ch2_out),
  .add_bus_valid_out(add_bus_valid_out), .add_bus_ready_in(add_bus_ready_in),
  .add_fifo_ready_out(add_fifo_ready_out), .add_overrun_out(add_overrun_out),
  .line_byte_ch6_valid_out(line_byte_ch6_valid_out),
  .line_byte_ch10_valid_out(line_byte_ch10_valid_out), .line_mode_out(line_mode_out));
